// ### cac_pkg.sv
// ===========================================================
// shared constants and types of the cell converter control
// ===========================================================
package cac_pkg;

   // ========================================================
   // clock and conversion timing
   // ========================================================
   localparam int unsigned CLK_HZ = 25_000_000;      // system clock rate
   localparam int unsigned T_CONV_US = 1000;         // primary conversion time, us
   localparam int unsigned CONV_CYC = (CLK_HZ / 1_000_000) * T_CONV_US; // cycles
   localparam int unsigned AVG_LEN = 8;              // samples per average window
   localparam int unsigned AVG_SHIFT = 3;            // divide by eight

   // ========================================================
   // widths
   // ========================================================
   localparam int unsigned NCH = 16;                 // channels per converter set
   localparam int unsigned DW = 16;                  // result width
   localparam int unsigned CODE_W = 11;              // command code width
   localparam int unsigned CNT_W = 6;                // command counter width
   localparam int unsigned AW = 8;                   // register address width
   localparam int unsigned TICK_W = 15;              // conversion cycle counter width

   // ========================================================
   // command code fields
   // ========================================================
   localparam int unsigned BIT_RD = 8;               // redundancy, cell command
   localparam int unsigned BIT_CONTINUOUS_BIT = 7;             // continuous_bit
   localparam int unsigned BIT_DCP = 4;              // discharge_permit_bit
   localparam int unsigned BIT_FILTER_RESET_BIT = 2;             // filter_reset_bit
   localparam int unsigned BIT_OW = 0;               // open_wire_select lsb

   // ========================================================
   // register map
   // ========================================================
   localparam logic [7:0] REG_CTRL = 8'h00;          // threshold, static discharge
   localparam logic [7:0] REG_STATUS = 8'h04;        // converter state
   localparam logic [7:0] REG_COUNT = 8'h08;         // command_counter
   localparam logic [7:0] REG_FAULT = 8'h0C;         // cell_compare_fault, w1c
   localparam int unsigned ROW_LSB = 6;              // result row select bits
   localparam int unsigned LANE_LSB = 2;             // result lane select bits
   localparam int unsigned CTRL_CTH_LSB = 0;         // compare_threshold field
   localparam int unsigned CTRL_DCC_LSB = 16;        // static_discharge_enable field
   localparam logic [31:0] CTRL_RST = 32'h0000_0000; // control after reset

   // result rows in memory
   localparam logic [1:0] ROW_CELL = 2'h0;           // latest primary results
   localparam logic [1:0] ROW_AVG = 2'h1;            // eight_sample_average
   localparam logic [1:0] ROW_SEC = 2'h2;            // secondary results

   // ========================================================
   // compare threshold code to limit in result lsb
   // ========================================================
   function automatic logic [15:0] cth_limit(input logic [2:0] code);
      logic [15:0] lim;
      lim = 16'h0000;
      unique case (code)
         3'h0: lim = 16'h0028;
         3'h1: lim = 16'h0050;
         3'h2: lim = 16'h0078;
         3'h3: lim = 16'h00A0;
         3'h4: lim = 16'h00C8;
         3'h5: lim = 16'h00F0;
         3'h6: lim = 16'h0140;
         3'h7: lim = 16'h0190;
      endcase
      return lim;
   endfunction

   // ========================================================
   // carriers and states
   // ========================================================
   typedef struct packed {
      logic valid;                                   // one-cycle command strobe
      logic [CODE_W-1:0] code;                       // command code
   } cac_cmd_t;

   typedef struct packed {
      logic wr;                                      // write strobe
      logic rd;                                      // read strobe
      logic [AW-1:0] addr;                           // byte address
      logic [31:0] wdata;                            // write data
   } cac_bus_req_t;

   typedef logic [NCH-1:0][DW-1:0] cac_chan_vec_t;   // one word per channel

   typedef enum logic [1:0] {C_OFF, C_SINGLE, C_REDUND, C_CONTINUOUS_BIT} cac_c_mode_t;
   typedef enum logic [1:0] {S_OFF, S_WAIT, S_SINGLE, S_CONTINUOUS_BIT} cac_s_mode_t;
   typedef enum logic [1:0] {H_NONE, H_UNTIL_CMD, H_C_DONE, H_S_DONE} cac_hold_t;

endpackage

// ### cac_result_mem.sv
`timescale 1ns/1ns
`default_nettype none
// ===========================================================
// result store: three rows of sixteen words, registered read
// ===========================================================
module cac_result_mem (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   input wire logic [2:0] row_we,
   input wire cac_pkg::cac_chan_vec_t row_wdata_0,
   input wire cac_pkg::cac_chan_vec_t row_wdata_1,
   input wire cac_pkg::cac_chan_vec_t row_wdata_2,
   input wire logic rd_en,
   input wire logic rd_mem,
   input wire logic [1:0] rd_row,
   input wire logic [3:0] rd_lane,
   input wire logic [31:0] rd_bypass,
   output logic [31:0] rdata_q
);

   cac_pkg::cac_chan_vec_t mem_q [3];               // stored rows

   // row writes, each row has its own port
   always_ff @(posedge clk_sys) begin
      if (ce) begin
         if (row_we[0]) begin
            mem_q[0] <= row_wdata_0;
         end
         if (row_we[1]) begin
            mem_q[1] <= row_wdata_1;
         end
         if (row_we[2]) begin
            mem_q[2] <= row_wdata_2;
         end
      end
   end

   // read register: memory word or register value from the caller
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata_q <= 32'h0000_0000;
      end else if (ce) begin
         if (!rd_en) begin
            rdata_q <= 32'h0000_0000;
         end else if (rd_mem && rd_row != 2'h3) begin
            rdata_q <= {16'h0000, mem_q[rd_row][rd_lane]};
         end else begin
            rdata_q <= rd_bypass;
         end
      end
   end

endmodule
`default_nettype wire

// ### cac_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - primary results each 1 ms, average each 8
// - secondary set converts independently every 8 ms
// - decode both eleven-bit convert command codes
// - count every valid convert command
// - new command aborts and restarts addressed converters
// - new command clears addressed result rows
// - continuous repeats, otherwise single measurement
// - continuous cleared: one last single, then off
// - redundant cell command compares average with secondary
// - secondary single: no compare, primaries unaffected
// - redundant cell command opens all wire switches
// - continuous secondary waits for average window end while primary continuous
// - compare-active status while comparison runs
// - rd0 dcp0 cont1: primary continuous, discharge untouched
// - rd1 dcp0 cont1: both continuous, discharge held off
// - rd1 dcp0 cont0: redundant single, discharge off meanwhile
// - all zero: primary single, rest untouched
// - dcp1 cont0: single conversion, discharge untouched
// - dcp1 cont1: ignored, counter unchanged
// - secondary dcp0 cont1: discharge stopped, secondary continuous
// - secondary dcp1 cont0: single, discharge continues
// - static discharge runs unless higher events interrupt
module cac_ctrl #(
   parameter int unsigned CONV_CYCLES = cac_pkg::CONV_CYC
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   input wire cac_pkg::cac_bus_req_t bus_req,
   output logic [31:0] rdata_q,
   input wire cac_pkg::cac_cmd_t cmd,
   input wire cac_pkg::cac_chan_vec_t c_data,
   input wire cac_pkg::cac_chan_vec_t s_data,
   input wire logic pwm_wave,
   input wire logic mute_req,
   input wire logic thermal_shutdown,
   input wire logic config_write_evt,
   output logic c_run_q,
   output logic s_run_q,
   output logic c_restart_q,
   output logic s_restart_q,
   output logic [1:0] open_wire_q,
   output logic filter_reset_q,
   output logic [15:0] discharge_q
);

   // ========================================================
   // command decode
   // ========================================================
   logic is_cell;                                    // cell_convert_cmd shape
   logic is_sec;                                     // secondary_convert_cmd shape
   logic bit_rd, bit_continuous_bit, bit_dcp;                  // control bits
   logic cmd_ok;                                     // accepted command
   logic cell_go, sec_go;                            // accepted per type

   // fixed code bits of both commands
   always_comb begin
      is_cell = cmd.code[10:9] == 2'h1 && cmd.code[6:5] == 2'h3
         && !cmd.code[3];
      is_sec = cmd.code[10:8] == 3'h1 && cmd.code[6:5] == 2'h3
         && cmd.code[3] && !cmd.code[2];
      bit_rd = cmd.code[cac_pkg::BIT_RD];
      bit_continuous_bit = cmd.code[cac_pkg::BIT_CONTINUOUS_BIT];
      bit_dcp = cmd.code[cac_pkg::BIT_DCP];
      cmd_ok = cmd.valid && (is_cell || is_sec) && !(bit_dcp && bit_continuous_bit);
      cell_go = cmd_ok && is_cell;
      sec_go = cmd_ok && is_sec;
   end

   // ========================================================
   // state
   // ========================================================
   cac_pkg::cac_c_mode_t c_mode_q;                   // primary set mode
   cac_pkg::cac_s_mode_t s_mode_q;                   // secondary set mode
   cac_pkg::cac_hold_t hold_q;                       // discharge hold reason
   logic cmp_q;                                      // compare enabled
   logic [cac_pkg::TICK_W-1:0] c_tick_q;             // primary cycle count
   logic [cac_pkg::TICK_W-1:0] s_tick_q;             // secondary cycle count
   logic [2:0] c_phase_q;                            // primary sample in window
   logic [2:0] s_phase_q;                            // secondary ms in conversion
   logic [31:0] ctrl_q;                              // control register
   logic [cac_pkg::CNT_W-1:0] count_q;               // command_counter
   logic [15:0] fault_q;                             // cell_compare_fault flags
   logic c_done, win_done, s_done;                   // conversion ends
   logic c_last, s_last;                             // last cycle of a ms

   // conversion end pulses
   always_comb begin
      c_last = c_tick_q == cac_pkg::TICK_W'(CONV_CYCLES - 1);
      s_last = s_tick_q == cac_pkg::TICK_W'(CONV_CYCLES - 1);
      c_done = c_mode_q != cac_pkg::C_OFF && c_last && !cell_go;
      win_done = c_done && c_phase_q == 3'(cac_pkg::AVG_LEN - 1);
      s_done = (s_mode_q == cac_pkg::S_SINGLE || s_mode_q == cac_pkg::S_CONTINUOUS_BIT)
         && s_last && s_phase_q == 3'h7 && !sec_go && !(cell_go && bit_rd);
   end

   // ========================================================
   // primary converter sequencing
   // ========================================================
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         c_mode_q <= cac_pkg::C_OFF;
         c_tick_q <= '0;
         c_phase_q <= 3'h0;
      end else if (ce) begin
         if (cell_go) begin
            // abort and restart, mode from the command bits
            c_tick_q <= '0;
            c_phase_q <= 3'h0;
            if (bit_continuous_bit) begin
               c_mode_q <= cac_pkg::C_CONTINUOUS_BIT;
            end else if (bit_rd) begin
               c_mode_q <= cac_pkg::C_REDUND;
            end else begin
               c_mode_q <= cac_pkg::C_SINGLE;
            end
         end else if (c_mode_q != cac_pkg::C_OFF) begin
            c_tick_q <= c_last ? '0 : c_tick_q + 1'b1;
            if (c_done) begin
               c_phase_q <= c_phase_q + 3'h1;
            end
            // single stops after one result, redundant after the window
            if (c_done && c_mode_q == cac_pkg::C_SINGLE) begin
               c_mode_q <= cac_pkg::C_OFF;
            end else if (win_done && c_mode_q == cac_pkg::C_REDUND) begin
               c_mode_q <= cac_pkg::C_OFF;
            end
         end
      end
   end

   // ========================================================
   // secondary converter sequencing
   // ========================================================
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_mode_q <= cac_pkg::S_OFF;
         s_tick_q <= '0;
         s_phase_q <= 3'h0;
      end else if (ce) begin
         if (cell_go && bit_rd) begin
            // redundant cell command starts both sets together
            s_mode_q <= bit_continuous_bit ? cac_pkg::S_CONTINUOUS_BIT : cac_pkg::S_SINGLE;
            s_tick_q <= '0;
            s_phase_q <= 3'h0;
         end else if (sec_go) begin
            s_tick_q <= '0;
            s_phase_q <= 3'h0;
            if (!bit_continuous_bit) begin
               s_mode_q <= cac_pkg::S_SINGLE;
            end else if (c_mode_q == cac_pkg::C_CONTINUOUS_BIT) begin
               s_mode_q <= cac_pkg::S_WAIT;
            end else begin
               s_mode_q <= cac_pkg::S_CONTINUOUS_BIT;
            end
         end else if (s_mode_q == cac_pkg::S_WAIT) begin
            // start aligned to the next primary window
            if (win_done) begin
               s_mode_q <= cac_pkg::S_CONTINUOUS_BIT;
            end else if (c_mode_q != cac_pkg::C_CONTINUOUS_BIT) begin
               s_mode_q <= cac_pkg::S_CONTINUOUS_BIT;
            end
         end else if (s_mode_q != cac_pkg::S_OFF) begin
            s_tick_q <= s_last ? '0 : s_tick_q + 1'b1;
            if (s_last) begin
               s_phase_q <= s_phase_q + 3'h1;
            end
            if (s_done && s_mode_q == cac_pkg::S_SINGLE) begin
               s_mode_q <= cac_pkg::S_OFF;
            end
         end
      end
   end

   // ========================================================
   // compare enable
   // ========================================================
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cmp_q <= 1'b0;
      end else if (ce) begin
         if (cell_go) begin
            // a cell command without redundancy leaves no aligned pair
            cmp_q <= bit_rd;
         end else if (sec_go) begin
            cmp_q <= bit_continuous_bit && c_mode_q == cac_pkg::C_CONTINUOUS_BIT;
         end else if (s_mode_q == cac_pkg::S_OFF || c_mode_q == cac_pkg::C_OFF) begin
            cmp_q <= 1'b0;
         end
      end
   end

   // ========================================================
   // averaging and comparison, one lane per channel
   // ========================================================
   cac_pkg::cac_chan_vec_t avg_now;                  // average incl. this sample
   logic [15:0] miss;                                // lanes over threshold
   logic [15:0] lim;                                 // threshold in lsb

   assign lim = cac_pkg::cth_limit(ctrl_q[cac_pkg::CTRL_CTH_LSB +: 3]);

   for (genvar i = 0; i < cac_pkg::NCH; i++) begin : g_lane
      logic [18:0] sum_q;                            // window sum
      logic [18:0] sum_all;                          // sum with current sample
      logic [15:0] diff;                             // absolute difference

      assign sum_all = (c_phase_q == 3'h0 ? 19'h00000 : sum_q) + 19'(c_data[i]);
      assign avg_now[i] = sum_all[18:3];
      assign diff = avg_now[i] > s_data[i] ? avg_now[i] - s_data[i]
         : s_data[i] - avg_now[i];
      assign miss[i] = diff > lim;

      // running sum restarts on every window
      always_ff @(posedge clk_sys) begin
         if (srst) begin
            sum_q <= 19'h00000;
         end else if (ce && c_done) begin
            sum_q <= sum_all;
         end
      end
   end

   // ========================================================
   // discharge hold and gate
   // ========================================================
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         hold_q <= cac_pkg::H_NONE;
      end else if (ce) begin
         if (cell_go && bit_rd && !bit_dcp) begin
            hold_q <= bit_continuous_bit ? cac_pkg::H_UNTIL_CMD : cac_pkg::H_C_DONE;
         end else if (sec_go && !bit_dcp) begin
            hold_q <= bit_continuous_bit ? cac_pkg::H_UNTIL_CMD : cac_pkg::H_S_DONE;
         end else if (sec_go || cell_go) begin
            // untouched discharge keeps any hold in place
            hold_q <= hold_q;
         end else if (hold_q == cac_pkg::H_C_DONE && win_done) begin
            hold_q <= cac_pkg::H_NONE;
         end else if (hold_q == cac_pkg::H_S_DONE && s_done) begin
            hold_q <= cac_pkg::H_NONE;
         end
      end
   end

   // per cell gate: static enable and pwm, unless interrupted
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         discharge_q <= 16'h0000;
      end else if (ce) begin
         if (hold_q != cac_pkg::H_NONE || mute_req || thermal_shutdown
               || config_write_evt) begin
            discharge_q <= 16'h0000;
         end else begin
            discharge_q <= ctrl_q[cac_pkg::CTRL_DCC_LSB +: 16] & {16{pwm_wave}};
         end
      end
   end

   // ========================================================
   // converter pins and command side effects
   // ========================================================
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         c_run_q <= 1'b0;
         s_run_q <= 1'b0;
         c_restart_q <= 1'b0;
         s_restart_q <= 1'b0;
         open_wire_q <= 2'h0;
         filter_reset_q <= 1'b0;
      end else if (ce) begin
         c_run_q <= c_mode_q != cac_pkg::C_OFF;
         s_run_q <= s_mode_q == cac_pkg::S_SINGLE || s_mode_q == cac_pkg::S_CONTINUOUS_BIT;
         c_restart_q <= cell_go;
         s_restart_q <= sec_go || (cell_go && bit_rd)
            || (s_mode_q == cac_pkg::S_WAIT && win_done);
         filter_reset_q <= cell_go && cmd.code[cac_pkg::BIT_FILTER_RESET_BIT];
         if (cmd_ok) begin
            // redundancy forces every switch open
            open_wire_q <= (cell_go && bit_rd) ? 2'h0
               : cmd.code[cac_pkg::BIT_OW +: 2];
         end
      end
   end

   // ========================================================
   // command counter, control and fault registers
   // ========================================================
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         count_q <= '0;
      end else if (ce && cmd_ok) begin
         count_q <= count_q + 1'b1;
      end
   end

   // control register, software written
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl_q <= cac_pkg::CTRL_RST;
      end else if (ce && bus_req.wr && bus_req.addr == cac_pkg::REG_CTRL) begin
         ctrl_q <= bus_req.wdata & 32'hFFFF_0007;
      end
   end

   // fault flags: set wins over write-one-to-clear
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fault_q <= 16'h0000;
      end else if (ce) begin
         fault_q <= (fault_q & ~((bus_req.wr && bus_req.addr == cac_pkg::REG_FAULT)
            ? bus_req.wdata[15:0] : 16'h0000))
            | ((cmp_q && s_done && win_done) ? miss : 16'h0000);
      end
   end

   // ========================================================
   // result rows and read port
   // ========================================================
   logic [2:0] row_we;                               // row write enables
   logic clr_c, clr_s;                               // row clears on command
   cac_pkg::cac_chan_vec_t wd_c, wd_a, wd_s;         // row write data
   logic [31:0] status;                              // status word

   always_comb begin
      clr_c = cell_go;
      clr_s = sec_go || (cell_go && bit_rd);
      row_we = {clr_s || s_done, clr_c || win_done, clr_c || c_done};
      wd_c = clr_c ? '0 : c_data;
      wd_a = clr_c ? '0 : avg_now;
      wd_s = clr_s ? '0 : s_data;
      status = {24'h000000, hold_q != cac_pkg::H_NONE,
         s_mode_q == cac_pkg::S_WAIT, c_mode_q == cac_pkg::C_CONTINUOUS_BIT,
         s_mode_q == cac_pkg::S_CONTINUOUS_BIT, c_run_q, s_run_q, 1'b0,
         cmp_q && s_mode_q != cac_pkg::S_OFF};
   end

   logic [31:0] reg_word;                            // register readback

   always_comb begin
      unique case (bus_req.addr)
         cac_pkg::REG_CTRL: reg_word = ctrl_q;
         cac_pkg::REG_STATUS: reg_word = status;
         cac_pkg::REG_COUNT: reg_word = 32'(count_q);
         cac_pkg::REG_FAULT: reg_word = {16'h0000, fault_q};
         default: reg_word = 32'h0000_0000;          // unmapped read as zero
      endcase
   end

   cac_result_mem u_mem (
      .clk_sys(clk_sys),
      .srst(srst),
      .ce(ce),
      .row_we(row_we),
      .row_wdata_0(wd_c),
      .row_wdata_1(wd_a),
      .row_wdata_2(wd_s),
      .rd_en(bus_req.rd),
      .rd_mem(bus_req.addr[7:6] != 2'h0),
      .rd_row(bus_req.addr[7:6] - 2'h1),
      .rd_lane(bus_req.addr[5:2]),
      .rd_bypass(reg_word),
      .rdata_q(rdata_q)
   );

endmodule
`default_nettype wire

// ### cac_ctrl_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// port checker: command decode and discharge
module cac_ctrl_checker (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   input wire cac_pkg::cac_cmd_t cmd,
   input wire logic mute_req,
   input wire logic c_restart_q,
   input wire logic s_restart_q,
   input wire logic s_run_q,
   input wire logic [1:0] open_wire_q,
   input wire logic filter_reset_q,
   input wire logic [15:0] discharge_q
);
   // common header, invalid dcp plus continuous_bit pair dropped
   wire logic hdr = cmd.valid & ce & (cmd.code[6:5] == 2'h3) & ~(cmd.code[4] & cmd.code[7]);
   wire logic cell_ok = hdr & (cmd.code[10:9] == 2'h1) & ~cmd.code[3];
   wire logic sec_ok = hdr & (cmd.code[10:8] == 3'h1) & (cmd.code[3:2] == 2'h2);
   wire logic [2:0] lo = cmd.code[2:0]; // filter and switch bits
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_red_take;
      cell_ok && cmd.code[8];
   endsequence
   property p_cell_rst; cell_ok |=> c_restart_q; endproperty
   a_cell_rst: assert property (p_cell_rst) else $error("cell restart missing");
   property p_sec_rst; sec_ok |=> s_restart_q; endproperty
   a_sec_rst: assert property (p_sec_rst) else $error("secondary restart missing");
   // a waiting secondary set may restart on a window end with no command
   property p_ignore; ce && !cell_ok && !sec_ok |=> !c_restart_q
      && (!s_restart_q || !s_run_q); endproperty
   a_ignore: assert property (p_ignore) else $error("restart without command");
   property p_ow_open; s_red_take |=> open_wire_q == 2'h0; endproperty
   a_ow_open: assert property (p_ow_open) else $error("switches not opened");
   property p_fields; cell_ok && !cmd.code[8] |=> {filter_reset_q, open_wire_q} == $past(lo);
   endproperty
   a_fields: assert property (p_fields) else $error("cell fields wrong");
   property p_sec_nf; sec_ok |=> !filter_reset_q; endproperty
   a_sec_nf: assert property (p_sec_nf) else $error("filter reset on secondary");
   property p_mute; ce && mute_req |=> discharge_q == 16'h0000; endproperty
   a_mute: assert property (p_mute) else $error("discharge during mute");
   property p_hold; s_red_take ##0 !cmd.code[4] |-> ##2 discharge_q == 16'h0000; endproperty
   a_hold: assert property (p_hold) else $error("discharge not held");
endmodule
bind cac_ctrl cac_ctrl_checker u_chk (.clk_sys, .srst, .ce, .cmd, .mute_req, .c_restart_q,
   .s_restart_q, .s_run_q, .open_wire_q, .filter_reset_q, .discharge_q);
`default_nettype wire

// ### cac_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// host side: one command strobe per request
module cac_host_model (
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [10:0] go_code,
   output cac_pkg::cac_cmd_t cmd
);
   initial cmd = '0;
   // idle code toggles so stale bits never pass as a command
   always @(posedge clk_sys) begin
      cmd.valid <= go;
      cmd.code <= go ? go_code : ~cmd.code;
   end
endmodule
`default_nettype wire

// ### cac_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bench: counter, single shot, discharge
module cac_ctrl_tb_top;
   localparam int unsigned NCYC = 10; // shortened conversion
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic go = 1'b0;
   logic [10:0] go_code = 11'h000;
   logic mute_req = 1'b0;
   cac_pkg::cac_bus_req_t bus_req = '0;
   cac_pkg::cac_cmd_t cmd;
   logic thermal_shutdown = 1'b0;
   logic config_write_evt = 1'b0;
   cac_pkg::cac_chan_vec_t c_data = {16{16'h0100}};
   cac_pkg::cac_chan_vec_t s_data = {16{16'h0100}};
   logic [31:0] rdata_q;
   logic [31:0] got;
   logic [15:0] discharge_q;
   int err_total = 0;
   int cmp_count = 0;
   cac_ctrl #(.CONV_CYCLES(NCYC)) dut (.clk_sys, .srst, .ce(1'b1), .bus_req, .rdata_q, .cmd,
      .c_data, .s_data, .pwm_wave(1'b1), .mute_req, .thermal_shutdown,
      .config_write_evt, .c_run_q(), .s_run_q(), .c_restart_q(), .s_restart_q(),
      .open_wire_q(), .filter_reset_q(), .discharge_q);
   cac_host_model host (.clk_sys, .go, .go_code, .cmd);
   initial forever #20 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic send(input logic [10:0] c);
      @(posedge clk_sys) go <= 1'b1;
      go_code <= c;
      @(posedge clk_sys) go <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys) bus_req <= '{1'b1, 1'b0, a, d};
      @(posedge clk_sys) bus_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys) bus_req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk_sys) bus_req <= '0;
      #1 got = rdata_q;
   endtask
   task automatic t_count;
      send(11'h260);
      send(11'h2F0);
      send(11'h1F8);
      send(11'h168);
      rd(8'h08);
      chk(got, 32'h2);
   endtask
   task automatic t_single;
      repeat (8 * NCYC + 5) @(posedge clk_sys);
      send(11'h260);
      rd(8'h40);
      chk(got, 32'h0);
      repeat (NCYC) @(posedge clk_sys);
      rd(8'h40);
      chk(got, 32'h0100);
   endtask
   task automatic t_dis;
      wr(8'h00, 32'hFFFF_0000);
      #50 chk({16'h0, discharge_q}, 32'hFFFF);
      @(posedge clk_sys) mute_req <= 1'b1;
      #50 chk({16'h0, discharge_q}, 32'h0);
      @(posedge clk_sys) {mute_req, thermal_shutdown} <= 2'b01;
      #50 chk({16'h0, discharge_q}, 32'h0);
      @(posedge clk_sys) {thermal_shutdown, config_write_evt} <= 2'b01;
      #50 chk({16'h0, discharge_q}, 32'h0);
      @(posedge clk_sys) config_write_evt <= 1'b0;
      send(11'h360);
      chk({16'h0, discharge_q}, 32'h0);
      rd(8'h04);
      chk(got, 32'h0000_008D);
      repeat (8 * NCYC + 10) @(posedge clk_sys);
      rd(8'h0C);
      chk(got, 32'h0);
      #50 chk({16'h0, discharge_q}, 32'hFFFF);
      send(11'h2E0);
      chk({16'h0, discharge_q}, 32'hFFFF);
      send(11'h1E8);
      rd(8'h04);
      chk(got, 32'h0000_00E9);
      chk({16'h0, discharge_q}, 32'h0);
      send(11'h260);
   endtask
   // redundant single with one lane off by more than the threshold
   task automatic t_fault;
      @(posedge clk_sys) s_data[0] <= 16'h0200;
      send(11'h360);
      repeat (8 * NCYC) @(posedge clk_sys);
      rd(8'h0C);
      chk(got, 32'h1);
      wr(8'h0C, 32'h1);
      rd(8'h0C);
      chk(got, 32'h0);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      t_count;
      t_single;
      t_dis;
      t_fault;
      report_and_stop;
   end
   initial begin
      repeat (3000) @(posedge clk_sys);
      err_total++;
      report_and_stop;
   end
endmodule
`default_nettype wire
